// >>> dso_ctrl_model.sv
`default_nettype none

// ====================================================================
// Controller standing on the terminals: it issues the run command.
module dso_ctrl_model
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Ready terminal seen and intent.
  input  wire logic rdy_term,
  input  wire logic want,
  input  wire logic rogue,
  // Command to the drive.
  output var  logic run_cmd
);
  timeunit 1ns;
  timeprecision 1ns;

  // A polite controller waits for ready; rogue exists only so that a
  // scenario can prove the drive ignores a command sent out of turn.
  // command while ready.
  always_ff @(posedge clk)
  begin
    if (rst)
      run_cmd <= 1'b0;
    else
      run_cmd <= want & (rdy_term | rogue);
  end
endmodule

`default_nettype wire

// >>> dso_ind_if.sv
`default_nettype none
`include "dso_regs.svh"

// ====================================================================
// Indications and selections travelling to the output router.
interface dso_ind_if;
  import dso_pkg::*;
  dso_ind_t                      ind;
  dso_sel_t [`DSO_NOUT-1:0]      sel;
  logic     [`DSO_NOUT-1:0]      out_q;

  modport src  (output ind, output sel, input out_q);
  modport sink (input ind, input sel, output out_q);
endinterface

`default_nettype wire

// >>> dso_out_mux.sv
`default_nettype none
`include "dso_regs.svh"

module dso_out_mux
  import dso_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Indications in, routed outputs back.
  dso_ind_if.sink  ifc
);

  // ==================================================================
  // Each output registers the indication its own code names, so a
  // change of code takes effect one cycle later without glitches.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ifc.out_q <= '0;
    end
    else
    begin
      for (int i = 0; i < `DSO_NOUT; i++)
      begin
        ifc.out_q[i] <= dso_pick(ifc.ind, ifc.sel[i]);
      end
    end
  end

endmodule

`default_nettype wire

// >>> dso_pkg.sv
`default_nettype none
`include "dso_regs.svh"

package dso_pkg;

  // ==================================================================
  // Types shared by the block.
  typedef logic [5:0] dso_sel_t;
  typedef logic [5:0] dso_ind_t;
  typedef enum logic {DSO_LC_ANY = 1'b0, DSO_LC_CONST = 1'b1} dso_lc_mode_t;

  // Map a selection code onto one indication; unknown codes give low.
  function automatic logic dso_pick(dso_ind_t ind, dso_sel_t code);
    logic r;
    r = 1'b0;
    unique case (code)
      `DSO_C_HOT:  r = ind[`DSO_I_HOT];
      `DSO_C_LOWI: r = ind[`DSO_I_LOWI];
      `DSO_C_RDY:  r = ind[`DSO_I_RDY];
      `DSO_C_FWD:  r = ind[`DSO_I_FWD];
      `DSO_C_REV:  r = ind[`DSO_I_REV];
      `DSO_C_MAJ:  r = ind[`DSO_I_MAJ];
      default:     r = 1'b0;
    endcase
    return r;
  endfunction

endpackage

`default_nettype wire

// >>> dso_regs.svh
`ifndef DSO_REGS_SVH
`define DSO_REGS_SVH

// ====================================================================
// Register map, byte addresses on the APB bus.
`define DSO_A_THR      8'h00
`define DSO_A_LOWI     8'h04
`define DSO_A_SEL0     8'h08
`define DSO_A_SELRY    8'h1C
`define DSO_A_STAT     8'h20
`define DSO_A_STEP     8'h04

// ====================================================================
// Field layout and limits.
`define DSO_THR_MAX    8'hC8
`define DSO_THR_RST    8'h64
`define DSO_LVL_MAX    8'h96
`define DSO_LVL_RST    8'h00
`define DSO_MODE_BIT   8
`define DSO_SEL_RST    6'h00
`define DSO_NOUT       6
`define DSO_NTERM      5
`define DSO_RELAY      5

// ====================================================================
// Function-selection codes.
`define DSO_C_HOT      6'h2A
`define DSO_C_LOWI     6'h2B
`define DSO_C_RDY      6'h32
`define DSO_C_FWD      6'h33
`define DSO_C_REV      6'h34
`define DSO_C_MAJ      6'h35

// ====================================================================
// Indication positions in the indication vector.
`define DSO_I_HOT      0
`define DSO_I_LOWI     1
`define DSO_I_RDY      2
`define DSO_I_FWD      3
`define DSO_I_REV      4
`define DSO_I_MAJ      5

// ====================================================================
// Hardware trip codes that count as a major failure.
`define DSO_E_CT       8'h0A
`define DSO_E_CPU      8'h0B
`define DSO_E_GND      8'h0E
`define DSO_E_FAN      8'h14
`define DSO_E_GATE     8'h17
`define DSO_E_MAIN     8'h19

`endif

// >>> dso_top.sv
`default_nettype none
`include "dso_regs.svh"

module dso_top
  import dso_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Drive state.
  input  wire logic [7:0]  heatsink_temp,
  input  wire logic [15:0] out_current,
  input  wire logic        drive_running,
  input  wire logic        drive_forward,
  input  wire logic        drive_reverse,
  input  wire logic        drive_stopping,
  input  wire logic        const_speed,
  input  wire logic        main_power_ok,
  input  wire logic        trip_active,
  input  wire logic [7:0]  trip_code,
  input  wire logic        run_cmd,
  // Terminals.
  output var  logic        cmd_accept,
  output var  logic        alarm_out,
  output var  logic [4:0]  term_out,
  output var  logic        relay_out
);

  // ==================================================================
  // Settings and bus state.
  logic [7:0]   overheat_threshold_setting_q;
  logic [7:0]   low_current_level_setting_q;
  dso_lc_mode_t low_current_mode_setting_q;
  dso_sel_t     sel_q [`DSO_NOUT];
  logic [31:0]  prdata_q;
  logic         cmd_accept_q;
  logic         alarm_q;
  logic         acc;
  logic         wr;
  logic         mapped;
  logic         is_sel;
  logic [2:0]   sel_idx;
  logic [7:0]   sel_off;
  dso_ind_t     ind;

  // Indication wires.
  logic heatsink_overheat_warn;
  logic low_current_ind;
  logic drive_ready_ind;
  logic forward_rotation_ind;
  logic reverse_rotation_ind;
  logic major_failure_ind;

  dso_ind_if ifc ();

  // ==================================================================
  // Address decode: the selection registers form one aligned run.
  always_comb
  begin
    sel_off = paddr - `DSO_A_SEL0;
    is_sel  = (paddr >= `DSO_A_SEL0) && (paddr <= `DSO_A_SELRY)
              && (paddr[1:0] == 2'h0);
    sel_idx = sel_off[4:2];
    mapped  = is_sel || (paddr == `DSO_A_THR) || (paddr == `DSO_A_LOWI)
              || (paddr == `DSO_A_STAT);
  end

  // Zero-wait slave; unmapped addresses answer with an error.
  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata  = prdata_q;

  // Read data is captured in the setup phase so it is ready at once.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata_q <= 32'h0000_0000;
      if (paddr == `DSO_A_THR)
      begin
        prdata_q[7:0] <= overheat_threshold_setting_q;
      end
      else if (paddr == `DSO_A_LOWI)
      begin
        prdata_q[7:0]           <= low_current_level_setting_q;
        prdata_q[`DSO_MODE_BIT] <= low_current_mode_setting_q;
      end
      else if (is_sel)
      begin
        prdata_q[5:0] <= sel_q[sel_idx];
      end
      else if (paddr == `DSO_A_STAT)
      begin
        prdata_q[11:0] <= {ifc.out_q, ind};
      end
    end
  end

  // ==================================================================
  // Threshold writes saturate so the stored value stays in range.
  // threshold 0..200
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      overheat_threshold_setting_q <= `DSO_THR_RST;
    end
    else if (wr && paddr == `DSO_A_THR)
    begin
      overheat_threshold_setting_q <=
        (pwdata[7:0] > `DSO_THR_MAX) ? `DSO_THR_MAX : pwdata[7:0];
    end
  end

  // Low-current level in hundredths of rated current, plus the mode.
  // level to 1.50
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      low_current_level_setting_q <= `DSO_LVL_RST;
      low_current_mode_setting_q  <= DSO_LC_ANY;
    end
    else if (wr && paddr == `DSO_A_LOWI)
    begin
      low_current_level_setting_q <=
        (pwdata[7:0] > `DSO_LVL_MAX) ? `DSO_LVL_MAX : pwdata[7:0];
      low_current_mode_setting_q  <=
        dso_lc_mode_t'(pwdata[`DSO_MODE_BIT]);
    end
  end

  // One selection register per output terminal and for the relay.
  // individual selections
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < `DSO_NOUT; i++)
      begin
        sel_q[i] <= `DSO_SEL_RST;
      end
    end
    else if (wr && is_sel)
    begin
      sel_q[sel_idx] <= pwdata[5:0];
    end
  end

  // ==================================================================
  // Indications are pure levels from present inputs and settings.
  // overheat compare
  assign heatsink_overheat_warn =
    heatsink_temp > overheat_threshold_setting_q;

  assign low_current_ind = drive_running
    && (out_current <= {8'h00, low_current_level_setting_q})
    && ((low_current_mode_setting_q == DSO_LC_ANY) || const_speed);

  // Tripped or unpowered main circuit cannot take a run command.
  // ready level
  assign drive_ready_ind = main_power_ok && !trip_active;

  // Deceleration to stop counts as stopping, not as driving.
  // forward drive
  assign forward_rotation_ind = drive_running && drive_forward
    && !drive_reverse && !drive_stopping;

  assign reverse_rotation_ind = drive_running && drive_reverse
    && !drive_forward && !drive_stopping;

  assign major_failure_ind = trip_active
    && ((trip_code == `DSO_E_CT)   || (trip_code == `DSO_E_CPU)
     || (trip_code == `DSO_E_GND)  || (trip_code == `DSO_E_FAN)
     || (trip_code == `DSO_E_GATE) || (trip_code == `DSO_E_MAIN));

  always_comb
  begin
    ind                = '0;
    ind[`DSO_I_HOT]    = heatsink_overheat_warn;
    ind[`DSO_I_LOWI]   = low_current_ind;
    ind[`DSO_I_RDY]    = drive_ready_ind;
    ind[`DSO_I_FWD]    = forward_rotation_ind;
    ind[`DSO_I_REV]    = reverse_rotation_ind;
    ind[`DSO_I_MAJ]    = major_failure_ind;
  end

  // ==================================================================
  // Routing to the terminals goes through one registered stage.
  assign ifc.ind = ind;

  always_comb
  begin
    for (int i = 0; i < `DSO_NOUT; i++)
    begin
      ifc.sel[i] = sel_q[i];
    end
  end

  dso_out_mux u_mux (
    .clk (clk),
    .rst (rst),
    .ifc (ifc.sink)
  );

  assign term_out  = ifc.out_q[`DSO_NTERM-1:0];
  assign relay_out = ifc.out_q[`DSO_RELAY];

  // ==================================================================
  // Run commands pass only while ready; others are dropped, not kept.
  // command gating
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmd_accept_q <= 1'b0;
    end
    else
    begin
      cmd_accept_q <= run_cmd && drive_ready_ind;
    end
  end

  // Ordinary alarm follows any trip, registered like the terminals.
  // alarm together
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      alarm_q <= 1'b0;
    end
    else
    begin
      alarm_q <= trip_active;
    end
  end

  assign cmd_accept = cmd_accept_q;
  assign alarm_out  = alarm_q;

  // ==================================================================
  // Checks on the driven behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_thr_write;
    psel && penable && pwrite && paddr == `DSO_A_THR;
  endsequence

  sequence s_sel0_write;
    psel && penable && pwrite && paddr == `DSO_A_SEL0;
  endsequence

  hot_route_a: assert property (
    sel_q[0] == `DSO_C_HOT && heatsink_temp > overheat_threshold_setting_q
    |=> term_out[0])
    else $error("overheat not routed to terminal 0");

  thr_clamp_a: assert property (
    s_thr_write and (pwdata[7:0] > `DSO_THR_MAX)
    |=> overheat_threshold_setting_q == `DSO_THR_MAX)
    else $error("threshold not clamped to 200");

  lowi_const_a: assert property (
    sel_q[`DSO_RELAY] == `DSO_C_LOWI
    && low_current_mode_setting_q == DSO_LC_CONST && !const_speed
    |=> !relay_out)
    else $error("low current shown outside constant speed");

  lowi_any_a: assert property (
    sel_q[1] == `DSO_C_LOWI && low_current_mode_setting_q == DSO_LC_ANY
    && drive_running
    && out_current <= {8'h00, low_current_level_setting_q}
    |=> term_out[1])
    else $error("low current missing in any-operation mode");

  rdy_power_a: assert property (
    sel_q[`DSO_RELAY] == `DSO_C_RDY && !main_power_ok |=> !relay_out)
    else $error("ready shown without main power");

  cmd_gate_a: assert property (
    cmd_accept |-> $past(run_cmd) && $past(main_power_ok)
    && !$past(trip_active))
    else $error("command accepted while not ready");

  dir_excl_a: assert property (
    !(forward_rotation_ind && reverse_rotation_ind)
    && !(drive_stopping && (forward_rotation_ind || reverse_rotation_ind)))
    else $error("rotation indications conflict");

  major_alarm_a: assert property (
    sel_q[2] == `DSO_C_MAJ && trip_active && trip_code == `DSO_E_GND
    |=> term_out[2] && alarm_out)
    else $error("major failure not shown with alarm");

  rev_route_a: assert property (
    sel_q[3] == `DSO_C_REV && drive_running && drive_reverse
    && !drive_forward && !drive_stopping |=> term_out[3])
    else $error("reverse rotation not routed");

  sel_take_a: assert property (
    s_sel0_write ##1 (sel_q[0] == `DSO_C_FWD && forward_rotation_ind)
    |=> term_out[0])
    else $error("new selection not applied");

endmodule

`default_nettype wire

// >>> dso_top_tb.sv
`default_nettype none
`include "dso_regs.svh"

module dso_top_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ==================================================================
  // Stimulus and observed signals.
  logic        clk, rst, psel, penable, pwrite, err, want, rogue;
  logic        run, fwd, rev, stp, cspd, pwr, trip, run_cmd;
  logic        pready, pslverr, cmd_accept, alarm_out, relay_out;
  logic [4:0]  term_out;
  logic [7:0]  paddr, temp, tcode;
  logic [15:0] cur;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch, cmp_count;

  dso_top i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .heatsink_temp(temp), .out_current(cur),
    .drive_running(run), .drive_forward(fwd), .drive_reverse(rev),
    .drive_stopping(stp), .const_speed(cspd), .main_power_ok(pwr),
    .trip_active(trip), .trip_code(tcode), .run_cmd, .cmd_accept,
    .alarm_out, .term_out, .relay_out);

  dso_ctrl_model i_ctrl (.clk, .rst, .rdy_term(term_out[0]), .want,
    .rogue, .run_cmd);

  // Free-running 100 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==================================================================
  // Shared tasks.
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; the idle edge at the end keeps psel from being
  // driven twice in one time step on back-to-back calls.
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(string nm, logic [7:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask

  // Four edges cover indication, output register and the controller.
  task automatic outs(string nm, logic [5:0] exp);
    repeat (4) @(posedge clk);
    chk(nm, {26'h0, relay_out, term_out}, {26'h0, exp});
  endtask

  task automatic sel_all(logic [5:0] code);
    for (int i = 0; i < 6; i++)
      wr(`DSO_A_SEL0 + 8'(4 * i), {26'h0, code});
  endtask

  // ==================================================================
  // Scenarios.
  task automatic t_regs();
    rdchk("thr rst", `DSO_A_THR, 32'h0000_0064);
    for (int i = 0; i < 6; i++)
      rdchk("sel rst", `DSO_A_SEL0 + 8'(4 * i), 32'h0000_0000);
    wr(`DSO_A_THR, 32'h0000_00ff);
    rdchk("thr sat", `DSO_A_THR, 32'h0000_00c8);
    wr(`DSO_A_LOWI, 32'h0000_01ff);
    rdchk("lvl sat", `DSO_A_LOWI, 32'h0000_0196);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk("unmapped", {31'h0, err}, 32'h0000_0001);
  endtask

  task automatic t_hot();
    logic [7:0] th [3] = '{8'h00, 8'h64, 8'hc8};
    sel_all(6'h2a);
    for (int i = 0; i < 3; i++)
    begin
      wr(`DSO_A_THR, {24'h0, th[i]});
      temp <= th[i];
      outs("hot eq", 6'h00);
      temp <= th[i] + 8'h01;
      outs("hot gt", 6'h3f);
    end
    temp <= 8'h00;
  endtask

  task automatic t_lowi();
    sel_all(6'h2b);
    wr(`DSO_A_LOWI, 32'h0000_0032);
    run <= 1'b1;
    cur <= 16'h0032;
    outs("low eq", 6'h3f);
    cur <= 16'h0033;
    outs("low above", 6'h00);
    cur <= 16'h0032;
    run <= 1'b0;
    outs("low idle", 6'h00);
    wr(`DSO_A_LOWI, 32'h0000_0132);
    run <= 1'b1;
    outs("low accel", 6'h00);
    cspd <= 1'b1;
    outs("low const", 6'h3f);
    run <= 1'b0;
    cspd <= 1'b0;
  endtask

  task automatic t_rdy();
    sel_all(6'h32);
    want <= 1'b1;
    outs("rdy on", 6'h3f);
    chk("cmd ok", {31'h0, cmd_accept}, 32'h0000_0001);
    pwr <= 1'b0;
    rogue <= 1'b1;
    outs("rdy nopwr", 6'h00);
    chk("cmd refused", {31'h0, cmd_accept}, 32'h0000_0000);
    rogue <= 1'b0;
    pwr <= 1'b1;
    trip <= 1'b1;
    outs("rdy trip", 6'h00);
    trip <= 1'b0;
    want <= 1'b0;
  endtask

  // Forward on terminals 0, 2, 4 and reverse on 1, 3 and the relay.
  // The drive already runs forward when the codes land, so a new
  // selection is seen taking effect on a live indication.
  task automatic t_rot();
    run <= 1'b1;
    fwd <= 1'b1;
    for (int i = 0; i < 6; i++)
      wr(`DSO_A_SEL0 + 8'(4 * i), (i % 2) ? 32'h0000_0034 : 32'h0000_0033);
    outs("fwd", 6'h15);
    chk("fwd on t2", {31'h0, term_out[2]}, 32'h0000_0001);
    fwd <= 1'b0;
    rev <= 1'b1;
    outs("rev", 6'h2a);
    stp <= 1'b1;
    outs("rev stop", 6'h00);
    rev <= 1'b0;
    fwd <= 1'b1;
    outs("fwd stop", 6'h00);
    stp <= 1'b0;
    run <= 1'b0;
    fwd <= 1'b0;
  endtask

  task automatic t_major();
    logic [7:0] cd [6] = '{8'h0a, 8'h0b, 8'h0e, 8'h14, 8'h17, 8'h19};
    sel_all(6'h35);
    trip <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      tcode <= cd[i];
      outs("major", 6'h3f);
      chk("alarm", {31'h0, alarm_out}, 32'h0000_0001);
    end
    // Only the major indication is up; all six outputs carry it.
    rdchk("stat", `DSO_A_STAT, 32'h0000_0fe0);
    tcode <= 8'h0c;
    outs("minor", 6'h00);
    trip <= 1'b0;
    outs("clear", 6'h00);
    chk("alarm off", {31'h0, alarm_out}, 32'h0000_0000);
  endtask

  // ==================================================================
  // Verdict, watchdog and main sequence.
  task automatic give_verdict();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // The run needs well under a thousand cycles; this cuts a hang.
  initial
  begin
    #100000;
    n_mismatch++;
    give_verdict();
  end

  // Reset, then every scenario in turn.
  initial
  begin
    {rst, psel, penable, pwrite, want, rogue} = 6'h20;
    {run, fwd, rev, stp, cspd, trip} = 6'h00;
    {paddr, temp, tcode, cur, pwdata} = '0;
    pwr = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_hot();
    t_lowi();
    t_rdy();
    t_rot();
    t_major();
    give_verdict();
  end
endmodule

`default_nettype wire
